// ---- hw/ftgc_cfg.sv ----
/*
  Output pin 0 configuration and FIFO level configuration registers, with
  the output pin driver, the wake trim loader and the threshold flags.
  Assumes the serial port logic presents byte reads and writes on the
  register port, and that fill counts and the wake pulse come from logic
  on the same clock.
*/
`timescale 1ns/10ps
module ftgc_cfg #(
   parameter logic [7:0] TRIM1_RESET = 8'h00,
   parameter logic [7:0] TRIM2_RESET = 8'h00,
   parameter int         NUM_SRC     = 64,
   parameter int         FILL_W      = 7
) (
   input  wire logic                       CORE_CLK_IN,
   input  wire logic                       NRST_IN,
   input  wire logic [ftgc_pkg::ADDR_W-1:0] REG_ADDR_IN,
   input  wire logic [7:0]                 REG_WDATA_IN,
   input  wire logic                       REG_WR_IN,
   input  wire logic                       REG_RD_IN,
   output logic                            REG_READY_OUT,
   output logic      [7:0]                 REG_RDATA_OUT,
   output logic                            REG_RVALID_OUT,
   input  wire logic                       REG_RREADY_IN,
   input  wire logic                       WAKE_IN,
   input  wire logic [NUM_SRC-1:0]         SIGNAL_SRC_IN,
   input  wire logic [FILL_W-1:0]          RX_FILL_IN,
   input  wire logic [FILL_W-1:0]          TX_FILL_IN,
   output logic                            GENERAL_OUTPUT_PIN0_OUT,
   output logic                            RX_THR_OUT,
   output logic                            TX_THR_OUT,
   output logic      [1:0]                 RX_ATTEN_CODE_OUT,
   output logic      [4:0]                 RX_ATTEN_DB_OUT,
   output logic      [7:0]                 TRIM1_OUT,
   output logic      [7:0]                 TRIM2_OUT
);

   typedef struct packed {
      logic [7:0] out0_cfg;
      logic [7:0] fifo_cfg;
      logic [7:0] trim1;
      logic [7:0] trim2;
      logic [7:0] div_cnt;
      logic       div_clk;
      logic       pin;
      logic       rx_thr;
      logic       tx_thr;
      logic [4:0] atten_db;
   } ftgc_state_s;

   ftgc_state_s state_reg;
   ftgc_state_s state_next;
   logic [5:0]  sel;
   logic        src_bit;
   logic        inv;
   logic        hold;
   logic [3:0]  thr;
   logic [1:0]  atten;
   logic [6:0]  rx_lvl;
   logic [6:0]  tx_lvl;
   logic [7:0]  rd_word;
   logic        rd_ok;

   // ****************************************
   // field decode
   // ****************************************
   // named views of the stored fields
   assign sel   = state_reg.out0_cfg[ftgc_pkg::SEL_MSB:ftgc_pkg::SEL_LSB];
   assign inv   = state_reg.out0_cfg[ftgc_pkg::INV_BIT];
   assign hold  = state_reg.fifo_cfg[ftgc_pkg::HOLD_BIT];
   assign thr   = state_reg.fifo_cfg[ftgc_pkg::THR_MSB:ftgc_pkg::THR_LSB];
   assign atten = state_reg.fifo_cfg[ftgc_pkg::ATTEN_MSB:ftgc_pkg::ATTEN_LSB];

   // R2 divided clock source
   assign src_bit = (sel == ftgc_pkg::CLK_SEL_CODE) ? state_reg.div_clk
                                                    : SIGNAL_SRC_IN[sel];

   // R10 levels from one field
   assign rx_lvl = ftgc_pkg::RX_LVL_BASE + ftgc_pkg::LVL_STEP * {3'h0, thr};
   assign tx_lvl = ftgc_pkg::TX_LVL_BASE - ftgc_pkg::LVL_STEP * {3'h0, thr};

   // ****************************************
   // register read path
   // ****************************************
   // R6 trim reads return reset
   always_comb begin
      case (REG_ADDR_IN)
         ftgc_pkg::OUT0_CFG_ADDR: rd_word = state_reg.out0_cfg;
         ftgc_pkg::FIFO_CFG_ADDR: rd_word = state_reg.fifo_cfg;
         ftgc_pkg::TRIM1_ADDR:    rd_word = TRIM1_RESET;
         ftgc_pkg::TRIM2_ADDR:    rd_word = TRIM2_RESET;
         default:                 rd_word = ftgc_pkg::UNMAPPED_DATA;
      endcase
   end

   assign rd_ok = REG_RD_IN & REG_READY_OUT;

   // read answers wait here while the port stalls
   ftgc_skid #(
      .WIDTH (8)
   ) u_rd_buf (
      .clk_in        (CORE_CLK_IN),
      .nrst_in       (NRST_IN),
      .in_data_in    (rd_word),
      .in_valid_in   (REG_RD_IN),
      .in_ready_out  (REG_READY_OUT),
      .out_data_out  (REG_RDATA_OUT),
      .out_valid_out (REG_RVALID_OUT),
      .out_ready_in  (REG_RREADY_IN)
   );

   // ****************************************
   // next state
   // ****************************************
   // register writes, divider, pin, trims and flags
   always_comb begin
      state_next = state_reg;
      if (REG_WR_IN && REG_ADDR_IN == ftgc_pkg::OUT0_CFG_ADDR) begin
         state_next.out0_cfg = REG_WDATA_IN;
      end
      if (REG_WR_IN && REG_ADDR_IN == ftgc_pkg::FIFO_CFG_ADDR) begin
         state_next.fifo_cfg = REG_WDATA_IN;
      end
      // R2 divide by 192
      if (state_reg.div_cnt == ftgc_pkg::CLK_HALF_M1) begin
         state_next.div_cnt = 8'h00;
         state_next.div_clk = ~state_reg.div_clk;
      end else begin
         state_next.div_cnt = state_reg.div_cnt + 8'h01;
      end
      // R1 polarity select
      state_next.pin = src_bit ^ inv;
      // R4 R5 wake trim load
      if (WAKE_IN) begin
         state_next.trim1 = hold ? ftgc_pkg::TRIM1_WAKE_SET : ftgc_pkg::TRIM1_WAKE_CLR;
         state_next.trim2 = hold ? ftgc_pkg::TRIM2_WAKE_SET : ftgc_pkg::TRIM2_WAKE_CLR;
      end
      // R9 R11 level compare
      state_next.rx_thr = RX_FILL_IN >= rx_lvl;
      state_next.tx_thr = TX_FILL_IN >= tx_lvl;
      // R8 attenuation step
      state_next.atten_db = ftgc_pkg::ATTEN_STEP_DB * {3'h0, atten};
   end

   // state register
   always_ff @(posedge CORE_CLK_IN) begin
      if (!NRST_IN) begin
         state_reg <= '0;
         state_reg.out0_cfg <= ftgc_pkg::OUT0_CFG_RESET;
         state_reg.fifo_cfg <= ftgc_pkg::FIFO_CFG_RESET;
         state_reg.trim1 <= TRIM1_RESET;
         state_reg.trim2 <= TRIM2_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign GENERAL_OUTPUT_PIN0_OUT = state_reg.pin;
   assign RX_THR_OUT              = state_reg.rx_thr;
   assign TX_THR_OUT              = state_reg.tx_thr;
   assign RX_ATTEN_CODE_OUT       = state_reg.fifo_cfg[ftgc_pkg::ATTEN_MSB:ftgc_pkg::ATTEN_LSB];
   assign RX_ATTEN_DB_OUT         = state_reg.atten_db;
   assign TRIM1_OUT               = state_reg.trim1;
   assign TRIM2_OUT               = state_reg.trim2;

   // ****************************************
   // assertions
   // ****************************************
   sequence s_wake_clr;
      WAKE_IN && !hold;
   endsequence
   sequence s_wake_set;
      WAKE_IN && hold;
   endsequence

   property p_pin_polarity;
      @(posedge CORE_CLK_IN) disable iff (!NRST_IN)
         $past(NRST_IN) |-> GENERAL_OUTPUT_PIN0_OUT == ($past(src_bit) ^ $past(inv));
   endproperty
   a_pin_polarity: assert property (p_pin_polarity) // R1
      else $error("output pin polarity wrong");

   property p_sel_reset;
      @(posedge CORE_CLK_IN) disable iff (!NRST_IN)
         $rose(NRST_IN) |-> sel == ftgc_pkg::CLK_SEL_CODE && thr == 4'h7;
   endproperty
   a_sel_reset: assert property (p_sel_reset) // R2
      else $error("configuration fields not at reset value");

   property p_wake_clr;
      @(posedge CORE_CLK_IN) disable iff (!NRST_IN)
         s_wake_clr |=> TRIM1_OUT == 8'h31 && TRIM2_OUT == 8'h88;
   endproperty
   a_wake_clr: assert property (p_wake_clr) // R4
      else $error("trims wrong after wake with hold clear");

   property p_wake_set;
      @(posedge CORE_CLK_IN) disable iff (!NRST_IN)
         s_wake_set |=> TRIM1_OUT == 8'h35 && TRIM2_OUT == 8'h81;
   endproperty
   a_wake_set: assert property (p_wake_set) // R5
      else $error("trims wrong after wake with hold set");

   property p_trim_read;
      @(posedge CORE_CLK_IN) disable iff (!NRST_IN)
         rd_ok && !REG_RVALID_OUT && REG_ADDR_IN == ftgc_pkg::TRIM1_ADDR
            |=> REG_RVALID_OUT && REG_RDATA_OUT == TRIM1_RESET;
   endproperty
   a_trim_read: assert property (p_trim_read) // R6
      else $error("trim read did not return reset value");

   property p_atten;
      @(posedge CORE_CLK_IN) disable iff (!NRST_IN)
         $past(NRST_IN) |-> RX_ATTEN_DB_OUT == 5'($past(atten) * 6);
   endproperty
   a_atten: assert property (p_atten) // R8
      else $error("attenuation value wrong");

   property p_rx_thr;
      @(posedge CORE_CLK_IN) disable iff (!NRST_IN)
         $past(NRST_IN) |-> RX_THR_OUT == ($past(RX_FILL_IN) >= 7'(4 * $past(thr) + 4));
   endproperty
   a_rx_thr: assert property (p_rx_thr) // R10
      else $error("receive threshold flag wrong");

   property p_tx_thr;
      @(posedge CORE_CLK_IN) disable iff (!NRST_IN)
         $past(NRST_IN) |-> TX_THR_OUT == ($past(TX_FILL_IN) >= 7'(61 - 4 * $past(thr)));
   endproperty
   a_tx_thr: assert property (p_tx_thr) // R9
      else $error("transmit threshold flag wrong");

endmodule

// ---- hw/ftgc_pkg.sv ----
/*
  Shared constants for the output pin and FIFO level configuration block:
  register offsets, field positions, reset values, wake trim values and
  threshold arithmetic.
  Assumes an 8-bit configuration register port with a 6-bit address.
*/
// Notes on behaviour
// R1 - invert bit high makes the selected output pin signal active low
// R2 - output select field resets to 63, the crystal clock divided by 192
// R3 - host should disable the clock output during initialisation
// R4 - hold bit clear loads trims 0x31 and 0x88 on each wake
// R5 - hold bit set loads trims 0x35 and 0x81 on each wake
// R6 - trim values only reach the analog side; reads return reset values
// R7 - host sets hold bit before sleep when narrow filters needed after wake
// R8 - attenuation code selects 0, 6, 12 or 18 dB
// R9 - threshold exceeded when fill count is at or above the level
// R10 - one field, reset 7: receive 4 plus 4n, transmit 61 minus 4n
// R11 - threshold flags recomputed every cycle from counts and setting
package ftgc_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam int         ADDR_W         = 6;
   localparam logic [5:0] OUT0_CFG_ADDR  = 6'h02;
   localparam logic [5:0] FIFO_CFG_ADDR  = 6'h03;
   localparam logic [5:0] TRIM2_ADDR     = 6'h2C;
   localparam logic [5:0] TRIM1_ADDR     = 6'h2D;
   localparam logic [7:0] OUT0_CFG_RESET = 8'h3F;
   localparam logic [7:0] FIFO_CFG_RESET = 8'h07;
   localparam logic [7:0] UNMAPPED_DATA  = 8'h00;

   // ****************************************
   // field positions
   // ****************************************
   localparam int INV_BIT   = 6;
   localparam int SEL_LSB   = 0;
   localparam int SEL_MSB   = 5;
   localparam int HOLD_BIT  = 6;
   localparam int ATTEN_LSB = 4;
   localparam int ATTEN_MSB = 5;
   localparam int THR_LSB   = 0;
   localparam int THR_MSB   = 3;

   // ****************************************
   // output select and divider
   // ****************************************
   localparam logic [5:0] CLK_SEL_CODE = 6'h3F;
   localparam int         CLK_DIV      = 192;
   localparam logic [7:0] CLK_HALF_M1  = 8'(CLK_DIV / 2 - 1);

   // ****************************************
   // wake trim values
   // ****************************************
   localparam logic [7:0] TRIM1_WAKE_CLR = 8'h31;
   localparam logic [7:0] TRIM2_WAKE_CLR = 8'h88;
   localparam logic [7:0] TRIM1_WAKE_SET = 8'h35;
   localparam logic [7:0] TRIM2_WAKE_SET = 8'h81;

   // ****************************************
   // threshold and attenuation arithmetic
   // ****************************************
   localparam logic [6:0] RX_LVL_BASE   = 7'h04;
   localparam logic [6:0] TX_LVL_BASE   = 7'h3D;
   localparam logic [6:0] LVL_STEP      = 7'h04;
   localparam logic [4:0] ATTEN_STEP_DB = 5'h06;

endpackage

// ---- hw/ftgc_skid.sv ----
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
module ftgc_skid #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk_in,
   input  wire logic             nrst_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   output logic      [WIDTH-1:0] out_data_out,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in
);

   typedef struct packed {
      logic [WIDTH-1:0] out_data;
      logic             out_valid;
      logic [WIDTH-1:0] spare_data;
      logic             spare_valid;
      logic             in_ready;
   } ftgc_buf_s;

   ftgc_buf_s state_reg;
   ftgc_buf_s state_next;
   logic      push;
   logic      pop;

   // ****************************************
   // next state
   // ****************************************
   // head refills from the spare first so order is kept
   always_comb begin
      state_next = state_reg;
      push = in_valid_in & state_reg.in_ready;
      pop = state_reg.out_valid & out_ready_in;
      if (pop || !state_reg.out_valid) begin
         if (state_reg.spare_valid) begin
            state_next.out_data = state_reg.spare_data;
            state_next.out_valid = 1'b1;
            state_next.spare_valid = 1'b0;
         end else begin
            state_next.out_data = in_data_in;
            state_next.out_valid = push;
         end
      end else if (push) begin
         state_next.spare_data = in_data_in;
         state_next.spare_valid = 1'b1;
      end
      state_next.in_ready = ~state_next.spare_valid;
   end

   // state register
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         state_reg <= '0;
         state_reg.in_ready <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   assign in_ready_out  = state_reg.in_ready;
   assign out_data_out  = state_reg.out_data;
   assign out_valid_out = state_reg.out_valid;

endmodule

// ---- tb/ftgc_host.sv ----
/*
  Host model: byte writes and reads on the register port.
  Assumes the port contract of the configuration block, one clock.
*/
`timescale 1ns/10ps
module ftgc_host (
   input  wire logic       clk_in,
   input  wire logic       ready_in,
   input  wire logic [7:0] rdata_in,
   input  wire logic       rvalid_in,
   output logic      [5:0] addr_out,
   output logic      [7:0] wdata_out,
   output logic            wr_out,
   output logic            rd_out,
   output logic            rready_out
);
   // idle port, released lines show the inverse
   initial begin
      addr_out = 6'h3F;
      wdata_out = 8'hFF;
      wr_out = 1'b0;
      rd_out = 1'b0;
      rready_out = 1'b1;
   end
   // one byte write
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
      addr_out <= ~a;
      wdata_out <= ~d;
   endtask
   // read request held until accepted
   task automatic rd_req(input logic [5:0] a);
      int n;
      n = 0;
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      do begin
         @(posedge clk_in);
         n++;
      end while (!ready_in && n < 50);
      rd_out <= 1'b0;
      addr_out <= ~a;
   endtask
   // request held three edges, counts accepts
   task automatic rd_refused(input logic [5:0] a, output int acc);
      acc = 0;
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      repeat (3) begin
         @(posedge clk_in);
         acc += int'(ready_in !== 1'b0); // an unknown ready counts as an accept
      end
      rd_out <= 1'b0;
      addr_out <= ~a;
   endtask
   // wait for the next answer
   task automatic rd_take(output logic [7:0] d);
      int n;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (!(rvalid_in && rready_out) && n < 50);
      d = rdata_in;
   endtask
   // slow consumer
   task automatic set_stall(input logic s);
      rready_out <= ~s;
   endtask
   task automatic init_cfg;
      wr(ftgc_pkg::OUT0_CFG_ADDR, 8'h00);
   endtask
   task automatic sleep_prep;
      wr(ftgc_pkg::FIFO_CFG_ADDR, 8'h47);
   endtask
endmodule

// ---- tb/test_fifo_threshold_and_output_pin0_cfg.sv ----
/*
  Self-checking bench for the configuration block with a host model.
  Assumes ftgc_pkg, ftgc_cfg and ftgc_host are compiled first.
*/
`timescale 1ns/10ps
module test_fifo_threshold_and_output_pin0_cfg;
   typedef struct packed {
      logic [7:0] cfg;
      logic [6:0] rx;
      logic [6:0] tx;
      logic       rt;
      logic       tt;
      logic [4:0] db;
   } ftgc_row_s;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        wake = 1'b0;
   logic [63:0] src = 64'h0;
   logic [6:0]  rxf = 7'h00;
   logic [6:0]  txf = 7'h00;
   logic [5:0]  addr;
   logic [7:0]  wdata, rdata, trim1, trim2, d;
   logic        wr, rd, ready, rvalid, rready, pin, rx_thr, tx_thr;
   logic [1:0]  code;
   logic [4:0]  db;
   logic [5:0]  sel;
   int          mismatches = 0;
   int          checks = 0;
   int          n, acc;
   ftgc_row_s   rows [6] = '{'{8'h00, 7'h04, 7'h3C, 1'b1, 1'b0, 5'h00},
      '{8'h11, 7'h07, 7'h39, 1'b0, 1'b1, 5'h06}, '{8'h27, 7'h20, 7'h20, 1'b1, 1'b0, 5'h0C},
      '{8'h3F, 7'h3F, 7'h01, 1'b0, 1'b1, 5'h12}, '{8'h0F, 7'h40, 7'h00, 1'b1, 1'b0, 5'h00},
      '{8'h8E, 7'h3B, 7'h05, 1'b0, 1'b1, 5'h00}};
   logic [5:0]  radr [5] = '{6'h02, 6'h03, 6'h2D, 6'h2C, 6'h10};
   logic [7:0]  rexp [5] = '{8'h3F, 8'h07, 8'hA5, 8'h5A, 8'h00};
   logic [5:0]  sels [3] = '{6'h00, 6'h05, 6'h3E};

   // 100 MHz clock
   always #5 clk = ~clk;

   ftgc_cfg #(.TRIM1_RESET(8'hA5), .TRIM2_RESET(8'h5A)) u_dut (
      .CORE_CLK_IN(clk), .NRST_IN(nrst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
      .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_READY_OUT(ready), .REG_RDATA_OUT(rdata),
      .REG_RVALID_OUT(rvalid), .REG_RREADY_IN(rready), .WAKE_IN(wake),
      .SIGNAL_SRC_IN(src), .RX_FILL_IN(rxf), .TX_FILL_IN(txf),
      .GENERAL_OUTPUT_PIN0_OUT(pin), .RX_THR_OUT(rx_thr), .TX_THR_OUT(tx_thr),
      .RX_ATTEN_CODE_OUT(code), .RX_ATTEN_DB_OUT(db), .TRIM1_OUT(trim1), .TRIM2_OUT(trim2));

   ftgc_host u_host (
      .clk_in(clk), .ready_in(ready), .rdata_in(rdata), .rvalid_in(rvalid),
      .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .rready_out(rready));

   // compare one value
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // read and compare
   task automatic rchk(input logic [5:0] a, input logic [7:0] e);
      logic [7:0] v;
      u_host.rd_req(a);
      u_host.rd_take(v);
      chk(v, e);
   endtask
   // cycles until the pin changes
   task automatic pin_gap(output int g);
      logic p;
      p = pin;
      g = 0;
      do begin
         @(posedge clk);
         g++;
      end while (pin === p && g < 300);
   endtask
   // one wake pulse, then trims
   task automatic wake_chk(input logic [7:0] e1, input logic [7:0] e2);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      @(posedge clk);
      chk(trim1, e1);
      chk(trim2, e2);
   endtask
   // verdict and end of run
   task automatic print_verdict;
      if (mismatches == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // watchdog
   initial begin
      #200000;
      mismatches++;
      print_verdict();
   end

   // main sequence
   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      chk(trim1, 8'hA5);
      pin_gap(n);
      pin_gap(n);
      chk(8'(n), 8'h60);
      u_host.wr(6'h10, 8'hFF);
      foreach (radr[i]) rchk(radr[i], rexp[i]);
      u_host.init_cfg();
      foreach (rows[i]) begin
         rxf <= rows[i].rx;
         txf <= rows[i].tx;
         u_host.wr(ftgc_pkg::FIFO_CFG_ADDR, rows[i].cfg);
         repeat (2) @(posedge clk);
         chk({7'h00, rx_thr}, {7'h00, rows[i].rt});
         chk({7'h00, tx_thr}, {7'h00, rows[i].tt});
         chk({6'h00, code}, {6'h00, rows[i].cfg[5:4]});
         chk({3'h0, db}, {3'h0, rows[i].db});
         rchk(ftgc_pkg::FIFO_CFG_ADDR, rows[i].cfg);
      end
      for (int k = 0; k < 12; k++) begin
         sel = sels[k / 4];
         src <= k[0] ? (64'h1 << sel) : ~(64'h1 << sel);
         u_host.wr(ftgc_pkg::OUT0_CFG_ADDR, {1'b0, k[1], sel});
         repeat (2) @(posedge clk);
         chk({7'h00, pin}, {7'h00, k[0] ^ k[1]});
      end
      wake_chk(8'h31, 8'h88);
      u_host.sleep_prep();
      wake_chk(8'h35, 8'h81);
      rchk(6'h2D, 8'hA5);
      rchk(6'h2C, 8'h5A);
      u_host.set_stall(1'b1);
      u_host.rd_req(ftgc_pkg::OUT0_CFG_ADDR);
      u_host.rd_req(ftgc_pkg::FIFO_CFG_ADDR);
      u_host.rd_refused(6'h10, acc);
      chk(8'(acc), 8'h00);
      u_host.set_stall(1'b0);
      u_host.rd_take(d);
      chk(d, 8'h7E);
      u_host.rd_take(d);
      chk(d, 8'h47);
      @(posedge clk);
      chk({7'h00, rvalid}, 8'h00);
      // second reset in mid-run: registers and trims go back to reset values
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      chk(trim1, 8'hA5);
      chk(trim2, 8'h5A);
      chk({7'h00, ready}, 8'h01);
      rchk(ftgc_pkg::FIFO_CFG_ADDR, 8'h07);
      rchk(ftgc_pkg::OUT0_CFG_ADDR, 8'h3F);
      print_verdict();
   end
endmodule
